// File: sas_regs.vh
`ifndef SAS_REGS_VH
`define SAS_REGS_VH
`define SAS_BITS          16
`define SAS_CONV_MAX_NS   3000
`define SAS_CLK_NS        8
`define SAS_STEP_CYC      8'h0A
`define SAS_POR_NS        20000
`define SAS_ADDR_CTRL     6'h00
`define SAS_ADDR_STAT     6'h04
`define SAS_ADDR_IRQ      6'h08
`define SAS_ADDR_MASK     6'h0C
`define SAS_ADDR_RESULT   6'h10
`define SAS_ADDR_ANALOG   6'h14
`define SAS_RESP_OKAY     2'b00
`define SAS_RESP_SLVERR   2'b10
`define SAS_EV_DONE       0
`define SAS_EV_IGNORED    1
`define SAS_EV_WORD_OUT   2
`endif

// File: sas_sync.v
`timescale 1ns/1ps
module sas_sync
#(
  parameter W = 1
)
(
  input  wire         clk,
  input  wire         rst_n,
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout
);
  reg [W-1:0] stage;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage <= {W{1'b0}};
      dout  <= {W{1'b0}};
    end
    else
    begin
      stage <= din;
      dout  <= stage;
    end
  end
endmodule

// File: sas_sar_core.v
`timescale 1ns/1ps
`include "sas_regs.vh"
module sas_sar_core
#(
  parameter BITS = `SAS_BITS
)
(
  input  wire            clk,
  input  wire            rst_n,
  input  wire            start,
  input  wire [BITS-1:0] analogIn,
  output reg             active,
  output reg             done,
  output reg  [BITS-1:0] dacCode,
  output reg  [BITS-1:0] result
);
  // --------------------------------------------------------------------------
  // Successive approximation over a digital model of the sampled input.
  // --------------------------------------------------------------------------
  reg [BITS-1:0] sample;
  reg [BITS-1:0] trialBit;
  reg [7:0]      stepCnt;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      active   <= 1'b0;
      done     <= 1'b0;
      dacCode  <= {BITS{1'b0}};
      result   <= {BITS{1'b0}};
      sample   <= {BITS{1'b0}};
      trialBit <= {BITS{1'b0}};
      stepCnt  <= 8'h00;
    end
    else
    begin
      done <= 1'b0;
      if (!active)
      begin
        if (start)
        begin
          active   <= 1'b1;
          sample   <= analogIn;
          trialBit <= {1'b1, {(BITS-1){1'b0}}};
          dacCode  <= {1'b1, {(BITS-1){1'b0}}};
          stepCnt  <= 8'h00;
        end
      end
      else if (stepCnt != `SAS_STEP_CYC)
        stepCnt <= stepCnt + 8'h01;
      else
      begin
        stepCnt <= 8'h00;
        // Keep the trial bit only when the DAC level does not exceed the input.
        if (dacCode > sample)
          dacCode <= (dacCode & ~trialBit) | (trialBit >> 1);
        else
          dacCode <= dacCode | (trialBit >> 1);
        trialBit <= trialBit >> 1;
        if (trialBit[0])
        begin
          active <= 1'b0;
          done   <= 1'b1;
          result <= (dacCode > sample) ? (dacCode & ~trialBit) : dacCode;
        end
      end
    end
  end
endmodule

// File: sas_adc_top.v
// Added by the designer: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "sas_regs.vh"
module sas_adc_top
#(
  parameter BITS   = `SAS_BITS,
  parameter POR_NS = `SAS_POR_NS
)
(
  input  wire            core_clk,
  input  wire            rst_n,
  input  wire            convertStart,
  input  wire            cascadeSelect,
  input  wire            readEnableOrCascadeIn,
  input  wire            serialClk,
  output reg             busy,
  output reg             serialOut,
  output reg             serialOutEn,
  output reg             corePowered,
  output reg             porReady,
  output reg             irq,
  input  wire [5:0]      s_axi_awaddr,
  input  wire            s_axi_awvalid,
  output reg             s_axi_awready,
  input  wire [31:0]     s_axi_wdata,
  input  wire [3:0]      s_axi_wstrb,
  input  wire            s_axi_wvalid,
  output reg             s_axi_wready,
  output reg  [1:0]      s_axi_bresp,
  output reg             s_axi_bvalid,
  input  wire            s_axi_bready,
  input  wire [5:0]      s_axi_araddr,
  input  wire            s_axi_arvalid,
  output reg             s_axi_arready,
  output reg  [31:0]     s_axi_rdata,
  output reg  [1:0]      s_axi_rresp,
  output reg             s_axi_rvalid,
  input  wire            s_axi_rready
);
  // --------------------------------------------------------------------------
  // Timing constants and state codes.
  // --------------------------------------------------------------------------
  localparam integer POR_CYC   = (POR_NS + `SAS_CLK_NS - 1) / `SAS_CLK_NS;
  localparam [1:0]   ST_ACQ    = 2'b00;
  localparam [1:0]   ST_CONV   = 2'b01;

  // --------------------------------------------------------------------------
  // Pin synchronisers.
  // --------------------------------------------------------------------------
  wire [3:0] pinSync;

  sas_sync #(.W(4)) u_sync
  (
    .clk   (core_clk),
    .rst_n (rst_n),
    .din   ({convertStart, cascadeSelect, readEnableOrCascadeIn, serialClk}),
    .dout  (pinSync)
  );

  wire cnvS   = pinSync[3];
  wire chainS = pinSync[2];
  wire rdlS   = pinSync[1];
  wire sckS   = pinSync[0];
  reg  cnvD;
  reg  sckD;
  wire cnvRise = cnvS & ~cnvD;
  wire sckRise = sckS & ~sckD;

  // --------------------------------------------------------------------------
  // Software controls, internal state and the SAR core.
  // --------------------------------------------------------------------------
  reg  [BITS-1:0] analogLevel;
  reg  [2:0]      irqStat;
  reg  [2:0]      irqMask;
  reg             swConvert;
  reg  [1:0]      state;
  reg  [31:0]     porCnt;
  reg  [BITS-1:0] shiftReg;
  reg  [5:0]      bitCnt;

  wire            coreActive;
  wire            coreDone;
  wire [BITS-1:0] coreResult;
  wire            startReq = cnvRise | swConvert;
  wire            coreStart = (state == ST_ACQ) & startReq;

  sas_sar_core #(.BITS(BITS)) u_core
  (
    .clk      (core_clk),
    .rst_n    (rst_n),
    .start    (coreStart),
    .analogIn (analogLevel),
    .active   (coreActive),
    .done     (coreDone),
    .dacCode  (),
    .result   (coreResult)
  );

  // --------------------------------------------------------------------------
  // Conversion sequencing.
  // --------------------------------------------------------------------------
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnvD        <= 1'b0;
      sckD        <= 1'b0;
      state       <= ST_ACQ;
      busy        <= 1'b0;
      corePowered <= 1'b0;
      porCnt      <= 32'h0000_0000;
      porReady    <= 1'b0;
    end
    else
    begin
      cnvD <= cnvS;
      sckD <= sckS;
      // The device cannot refuse an early start; this flag only reports it.
      if (porCnt < POR_CYC)
        porCnt <= porCnt + 32'h0000_0001;
      else
        porReady <= 1'b1;
      case (state)
        ST_ACQ:
        begin
          if (startReq)
          begin
            state       <= ST_CONV;
            busy        <= 1'b1;
            corePowered <= 1'b1;
          end
        end
        ST_CONV:
        begin
          // New convert edges are ignored here, so a running search is never restarted.
          if (coreDone)
          begin
            state       <= ST_ACQ;
            busy        <= 1'b0;
            corePowered <= 1'b0;
          end
        end
        default:
          state <= ST_ACQ;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Serial output path.
  // --------------------------------------------------------------------------
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shiftReg    <= {BITS{1'b0}};
      serialOut   <= 1'b0;
      serialOutEn <= 1'b0;
      bitCnt      <= 6'h00;
    end
    else
    begin
      // In cascade mode the output is always driven.
      serialOutEn <= chainS | ~rdlS;
      if (coreDone)
      begin
        shiftReg  <= coreResult;
        serialOut <= coreResult[BITS-1];
        bitCnt    <= 6'h00;
      end
      else if (sckRise && (chainS || !rdlS))
      begin
        // Upstream bits refill the tail so they follow the own word.
        shiftReg  <= {shiftReg[BITS-2:0], chainS & rdlS};
        serialOut <= shiftReg[BITS-2];
        bitCnt    <= (bitCnt == BITS - 1) ? 6'h00 : bitCnt + 6'h01;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Register bus and interrupts.
  // --------------------------------------------------------------------------
  wire [2:0] events = {(sckRise && (chainS || !rdlS) && bitCnt == BITS - 1),
                       (state == ST_CONV) & cnvRise, coreDone};
  wire       wrFire = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  wire [5:0] wa     = s_axi_awaddr;

  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `SAS_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `SAS_RESP_OKAY;
      analogLevel   <= {BITS{1'b0}};
      irqStat       <= 3'h0;
      irqMask       <= 3'h0;
      swConvert     <= 1'b0;
      irq           <= 1'b0;
    end
    else
    begin
      s_axi_awready <= wrFire & ~s_axi_awready;
      s_axi_wready  <= wrFire & ~s_axi_wready;
      swConvert     <= 1'b0;
      if (wrFire && !s_axi_awready)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `SAS_RESP_OKAY;
        if (wa == `SAS_ADDR_CTRL)
          swConvert <= s_axi_wstrb[0] & s_axi_wdata[0];
        else if (wa == `SAS_ADDR_IRQ)
          irqStat <= (irqStat & ~(s_axi_wdata[2:0] & {3{s_axi_wstrb[0]}})) | events;
        else if (wa == `SAS_ADDR_MASK)
        begin
          if (s_axi_wstrb[0])
            irqMask <= s_axi_wdata[2:0];
        end
        else if (wa == `SAS_ADDR_ANALOG)
        begin
          if (s_axi_wstrb[0])
            analogLevel[7:0] <= s_axi_wdata[7:0];
          if (s_axi_wstrb[1])
            analogLevel[15:8] <= s_axi_wdata[15:8];
        end
        else
          s_axi_bresp <= `SAS_RESP_SLVERR;
        if (wa != `SAS_ADDR_IRQ)
          irqStat <= irqStat | events;
      end
      else
      begin
        irqStat <= irqStat | events;
        if (s_axi_bvalid && s_axi_bready)
          s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= s_axi_arvalid & ~s_axi_rvalid & ~s_axi_arready;
      if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `SAS_RESP_OKAY;
        if (s_axi_araddr == `SAS_ADDR_CTRL)
          s_axi_rdata <= 32'h0000_0000;
        else if (s_axi_araddr == `SAS_ADDR_STAT)
          s_axi_rdata <= {26'h0, bitCnt == 6'h00, chainS, porReady, corePowered, coreActive, busy};
        else if (s_axi_araddr == `SAS_ADDR_IRQ)
          s_axi_rdata <= {29'h0, irqStat};
        else if (s_axi_araddr == `SAS_ADDR_MASK)
          s_axi_rdata <= {29'h0, irqMask};
        else if (s_axi_araddr == `SAS_ADDR_RESULT)
          s_axi_rdata <= {16'h0000, shiftReg};
        else if (s_axi_araddr == `SAS_ADDR_ANALOG)
          s_axi_rdata <= {16'h0000, analogLevel};
        else
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `SAS_RESP_SLVERR;
        end
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
      irq <= |(irqStat & irqMask);
    end
  end
endmodule

// File: sas_adc_assertions.sv
`timescale 1ns/1ps
module sas_adc_checker
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic convertStart,
  input wire logic cascadeSelect,
  input wire logic readEnableOrCascadeIn,
  input wire logic serialClk,
  input wire logic busy,
  input wire logic serialOut,
  input wire logic serialOutEn,
  input wire logic corePowered
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_cnvEdge;
    $rose(convertStart) && !busy;
  endsequence
  sequence s_linkQuiet;
    !busy && !$fell(busy) && $stable(serialClk) && $stable(cascadeSelect);
  endsequence
  property p_cnvBusy;
    s_cnvEdge |-> ##[1:6] busy;
  endproperty
  a_cnvBusy: assert property (p_cnvBusy) else $error("busy missing after convert");
  property p_busyHold;
    $rose(busy) |=> busy[*8];
  endproperty
  a_busyHold: assert property (p_busyHold) else $error("busy dropped early");
  property p_busyMax;
    $rose(busy) |-> ##[1:375] !busy;
  endproperty
  a_busyMax: assert property (p_busyMax) else $error("conversion too long");
  property p_powerUp;
    $rose(busy) |-> ##[0:2] corePowered;
  endproperty
  a_powerUp: assert property (p_powerUp) else $error("core not powered");
  property p_powerDown;
    $fell(busy) |-> ##[0:2] !corePowered;
  endproperty
  a_powerDown: assert property (p_powerDown) else $error("core stays powered");
  property p_enNormal;
    (!cascadeSelect && !readEnableOrCascadeIn)[*6] |-> serialOutEn;
  endproperty
  a_enNormal: assert property (p_enNormal) else $error("output not enabled");
  property p_floatNormal;
    (!cascadeSelect && readEnableOrCascadeIn)[*6] |-> !serialOutEn;
  endproperty
  a_floatNormal: assert property (p_floatNormal) else $error("output not floated");
  property p_enChain;
    cascadeSelect[*6] |-> serialOutEn;
  endproperty
  a_enChain: assert property (p_enChain) else $error("chain output off");
  property p_sdoHold;
    s_linkQuiet[*8] |-> $stable(serialOut);
  endproperty
  a_sdoHold: assert property (p_sdoHold) else $error("data moved without clock");
endmodule

bind sas_adc_top sas_adc_checker u_chk
(
  .core_clk(core_clk), .rst_n(rst_n), .convertStart(convertStart), .cascadeSelect(cascadeSelect),
  .readEnableOrCascadeIn(readEnableOrCascadeIn), .serialClk(serialClk), .busy(busy),
  .serialOut(serialOut), .serialOutEn(serialOutEn), .corePowered(corePowered)
);

// File: sas_host_model.sv
`timescale 1ns/1ps
module sas_host_model
(
  input  wire logic core_clk,
  input  wire logic busy,
  input  wire logic porReady,
  input  wire logic serialOut,
  input  wire logic chain,
  input  wire logic readEnable_n,
  output logic      convertStart,
  output logic      serialClk,
  output wire logic readEnableOrCascadeIn
);
  logic upBit;
  initial
  begin
    convertStart = 1'b0;
    serialClk = 1'b0;
    upBit = 1'b0;
  end
  assign readEnableOrCascadeIn = chain ? upBit : readEnable_n;
  task automatic convert(input int pulses);
    wait (porReady === 1'b1);
    repeat (pulses)
    begin
      @(posedge core_clk) convertStart <= 1'b1;
      repeat (3) @(posedge core_clk);
      convertStart <= 1'b0;
      repeat (3) @(posedge core_clk);
    end
    do @(posedge core_clk); while (busy !== 1'b0);
  endtask
  // The serial clock takes eight core cycles per period and rests low between frames.
  task automatic shift(input int n, input logic [31:0] up, output logic [31:0] word);
    word = 32'h0000_0000;
    for (int k = 0; k < n; k++)
    begin
      @(posedge core_clk);
      upBit <= up[31-k];
      word = {word[30:0], serialOut};
      @(posedge core_clk) serialClk <= 1'b1;
      repeat (4) @(posedge core_clk);
      serialClk <= 1'b0;
      repeat (2) @(posedge core_clk);
    end
  endtask
endmodule

// File: sas_adc_tb_top.sv
`timescale 1ns/1ps
`include "sas_regs.vh"
module sas_adc_tb_top;
  logic        core_clk = 1'b0, rst_n = 1'b0, cascadeSelect = 1'b0, readEnable_n = 1'b0;
  logic        convertStart, serialClk, readEnableOrCascadeIn, busy, serialOut;
  logic        serialOutEn, corePowered, porReady, irq, awReady, wReady, bValid, arReady, rValid;
  logic        awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
  logic [5:0]  awAddr = 6'h00, arAddr = 6'h00;
  logic [31:0] wData = 32'h0000_0000, rData, w, got;
  logic [1:0]  bResp, rResp, lastResp;
  int          mismatches = 0, samples_checked = 0, cycles = 0;
  logic [31:0] rows [4] = '{32'h0000_0000, 32'hFFFF_FFFF, 32'h8001_8001, 32'h1234_1234};
  always #4 core_clk = ~core_clk;
  sas_adc_top #(.POR_NS(800)) dut
  (
    .core_clk(core_clk), .rst_n(rst_n), .convertStart(convertStart), .cascadeSelect(cascadeSelect),
    .readEnableOrCascadeIn(readEnableOrCascadeIn), .serialClk(serialClk), .busy(busy),
    .serialOut(serialOut), .serialOutEn(serialOutEn), .corePowered(corePowered), .porReady(porReady),
    .irq(irq), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
    .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
    .s_axi_rvalid(rValid), .s_axi_rready(rReady)
  );
  sas_host_model host
  (
    .core_clk(core_clk), .busy(busy), .porReady(porReady), .serialOut(serialOut), .chain(cascadeSelect),
    .readEnable_n(readEnable_n), .convertStart(convertStart), .serialClk(serialClk),
    .readEnableOrCascadeIn(readEnableOrCascadeIn)
  );
  task automatic print_verdict();
    if (mismatches == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic axiWr(input logic [5:0] a, input logic [31:0] d);
    @(posedge core_clk);
    awAddr <= a; wData <= d; awValid <= 1'b1; wValid <= 1'b1; bReady <= 1'b1;
    do
    begin
      @(posedge core_clk);
      if (awReady) awValid <= 1'b0;
      if (wReady) wValid <= 1'b0;
    end while (bValid !== 1'b1);
    lastResp = bResp;
    bReady <= 1'b0;
  endtask
  task automatic rdChk(input logic [5:0] a, input logic [31:0] e);
    @(posedge core_clk);
    arAddr <= a; arValid <= 1'b1; rReady <= 1'b1;
    do
    begin
      @(posedge core_clk);
      if (arReady) arValid <= 1'b0;
    end while (rValid !== 1'b1);
    got = rData;
    lastResp = rResp;
    rReady <= 1'b0;
    chk(got, e);
  endtask
  // ------------------------------------------------------------------
  // Timeout: a hang counts as a mismatch.
  // ------------------------------------------------------------------
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      mismatches++;
      print_verdict();
    end
  end
  initial
  begin
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    chk({31'b0, porReady}, 32'h0000_0000);
    rdChk(6'h18, 32'h0000_0000);
    chk({30'b0, lastResp}, {30'b0, `SAS_RESP_SLVERR});
    axiWr(6'(`SAS_ADDR_MASK), 32'h0000_0001);
    foreach (rows[i])
    begin
      axiWr(6'(`SAS_ADDR_ANALOG), {16'h0000, rows[i][31:16]});
      host.convert(1);
      rdChk(6'(`SAS_ADDR_RESULT), {16'h0000, rows[i][15:0]});
      chk({31'b0, irq}, 32'h0000_0001);
      host.shift(16, 32'h0000_0000, w);
      chk(w, {16'h0000, rows[i][15:0]});
      axiWr(6'(`SAS_ADDR_IRQ), 32'h0000_0007);
    end
    repeat (2) @(posedge core_clk);
    chk({31'b0, irq}, 32'h0000_0000);
    // Second edge lands while busy; it must be dropped and flagged.
    axiWr(6'(`SAS_ADDR_ANALOG), 32'h0000_7FFE);
    host.convert(2);
    rdChk(6'(`SAS_ADDR_IRQ), 32'h0000_0003);
    rdChk(6'(`SAS_ADDR_RESULT), 32'h0000_7FFE);
    axiWr(6'(`SAS_ADDR_IRQ), 32'h0000_0007);
    axiWr(6'(`SAS_ADDR_MASK), 32'h0000_0000);
    @(posedge core_clk) readEnable_n <= 1'b1;
    repeat (8) @(posedge core_clk);
    chk({31'b0, serialOutEn}, 32'h0000_0000);
    readEnable_n <= 1'b0;
    cascadeSelect <= 1'b1;
    axiWr(6'(`SAS_ADDR_ANALOG), 32'h0000_C3A5);
    host.convert(1);
    chk({31'b0, irq}, 32'h0000_0000);
    chk({31'b0, serialOutEn}, 32'h0000_0001);
    host.shift(32, 32'h5A0F_0000, w);
    chk(w, 32'hC3A5_5A0F);
    rdChk(6'(`SAS_ADDR_STAT), 32'h0000_0038);
    axiWr(6'h1C, 32'h0000_0000);
    chk({30'b0, lastResp}, {30'b0, `SAS_RESP_SLVERR});
    axiWr(6'(`SAS_ADDR_CTRL), 32'h0000_0001);
    repeat (2) @(posedge core_clk);
    chk({31'b0, busy}, 32'h0000_0001);
    do @(posedge core_clk); while (busy !== 1'b0);
    rdChk(6'(`SAS_ADDR_RESULT), 32'h0000_C3A5);
    print_verdict();
  end
endmodule
